/* adc_port_params.svh */
// constants for the converter serial result port
`ifndef ADC_PORT_PARAMS_SVH
`define ADC_PORT_PARAMS_SVH
`define CLK_FREQ_MHZ 250
`define CONV_TIME_US 16600
`define CONV_CYCLES (`CONV_TIME_US * `CLK_FREQ_MHZ)
`define RESULT_BITS 16
`define BIT_CNT_W 5
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define MID_SCALE 16'h8000
`endif

/* adc_port_pkg.sv */
// types for the converter serial result port
package adc_port_pkg;
  typedef enum logic [1:0] {
    st_convert,
    st_sleep,
    st_output
  } cycle_state_e;
  typedef struct packed {
    logic cs_n;
    logic sck;
  } link_in_s;
  typedef struct packed {
    logic data_o;
    logic data_oe;
  } link_out_s;
endpackage

/* adc_port_sva.sv */
// pin-level assertions for the serial result port
`timescale 1ns/1ps
`default_nettype none
module adc_port_sva #(
  parameter int CONV_CYCLES = 200
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic data_o,
  input wire logic data_oe,
  input wire logic converting
);
  int cnt_reg;
  int low_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge clk) begin
    if (!resetn) cnt_reg <= 0;
    else cnt_reg <= converting ? cnt_reg + 1 : 0;
  end
  always_ff @(posedge clk) begin
    if (!resetn) low_reg <= 0;
    else low_reg <= converting ? 0 : low_reg + 1;
  end
  a_oe_off_high: assert property (cs_n [*5] |-> !data_oe)
    else $error("oe on");
  a_oe_on_low: assert property (!cs_n [*5] |-> data_oe)
    else $error("oe off");
  a_status_busy: assert property ((converting && data_oe) [*4] |-> data_o)
    else $error("busy low");
  a_conv_len: assert property ($fell(converting) |->
    cnt_reg >= CONV_CYCLES - 2 && cnt_reg <= CONV_CYCLES + 2)
    else $error("conv len");
  a_conv_hold: assert property (converting && cnt_reg < CONV_CYCLES - 2
    |=> converting)
    else $error("conv cut");
  a_no_shift: assert property (converting [*4] |-> $stable(data_o))
    else $error("shift busy");
  a_sleep_stays: assert property ($fell(converting) |-> !converting [*8])
    else $error("sleep left");
  a_shift_fall: assert property ($changed(data_o) && low_reg > 4 |-> !sck)
    else $error("shift no fall");
endmodule
bind adc_serial_result_port adc_port_sva #(.CONV_CYCLES(CONV_CYCLES)) u_sva (
  .clk(clk), .resetn(resetn), .cs_n(cs_n), .sck(sck),
  .data_o(data_o), .data_oe(data_oe), .converting(converting));
`default_nettype wire

/* adc_serial_result_port.sv */
// convert, sleep and serial data output cycle of the converter
`include "adc_port_params.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_serial_result_port
  import adc_port_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic [`RESULT_BITS-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic data_o,
  output logic data_oe,
  output logic converting
);
  link_in_s sync1_reg;
  link_in_s sync2_reg;
  link_in_s prev_reg;
  link_out_s pin_reg;
  cycle_state_e state_reg;
  logic [31:0] conv_cnt_reg;
  logic [`RESULT_BITS-1:0] result_reg;
  logic [`RESULT_BITS-1:0] shift_reg;
  logic [`BIT_CNT_W-1:0] bit_cnt_reg;
  logic sck_fall;
  logic cs_rise;
  logic conv_done;
  logic last_fall;
  logic [`RESULT_BITS-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_take;

  // synchronise the pins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_reg <= '{cs_n: 1'b1, sck: 1'b1};
      sync2_reg <= '{cs_n: 1'b1, sck: 1'b1};
      prev_reg <= '{cs_n: 1'b1, sck: 1'b1};
    end else begin
      sync1_reg <= '{cs_n: cs_n, sck: sck};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign sck_fall = prev_reg.sck && !sync2_reg.sck;
  assign cs_rise = !prev_reg.cs_n && sync2_reg.cs_n;
  assign conv_done = (conv_cnt_reg == 32'(CONV_CYCLES - 1));
  // sixteenth falling edge closes the output phase
  assign last_fall = sck_fall &&
    (bit_cnt_reg == `BIT_CNT_W'(`RESULT_BITS - 1));
  // sample taken at end of conversion; missing sample gives mid-scale
  assign fifo_take = (state_reg == st_convert) && conv_done;

  result_fifo #(
    .WIDTH(`RESULT_BITS),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  // conversion timer, runs only in convert
  always_ff @(posedge clk) begin
    if (!resetn) begin
      conv_cnt_reg <= '0;
    end else if (state_reg == st_convert && !conv_done) begin
      conv_cnt_reg <= conv_cnt_reg + 32'h1;
    end else begin
      conv_cnt_reg <= '0;
    end
  end

  // cycle state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= st_convert;
    end else begin
      case (state_reg)
        st_convert: begin
          if (conv_done) begin
            state_reg <= st_sleep;
          end
        end
        st_sleep: begin
          if (!sync2_reg.cs_n && !sync2_reg.sck) begin
            state_reg <= st_output;
          end
        end
        st_output: begin
          if (cs_rise) begin
            state_reg <= st_convert;
          end else if (last_fall) begin
            state_reg <= st_convert;
          end
        end
        default: begin
          state_reg <= st_convert;
        end
      endcase
    end
  end

  // held result
  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_reg <= `MID_SCALE;
    end else if (fifo_take) begin
      result_reg <= fifo_valid ? fifo_data : `MID_SCALE;
    end
  end

  // shifter, msb first
  always_ff @(posedge clk) begin
    if (!resetn) begin
      shift_reg <= '0;
    end else if (state_reg == st_sleep) begin
      shift_reg <= result_reg;
    end else if (state_reg == st_output && sck_fall) begin
      shift_reg <= {shift_reg[`RESULT_BITS-2:0], 1'b0};
    end
  end

  // falling edges counted in output
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bit_cnt_reg <= '0;
    end else if (state_reg == st_sleep) begin
      bit_cnt_reg <= '0;
    end else if (state_reg == st_output && sck_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
    end
  end

  // output enable; select is sampled so the 100 ns enable limit holds
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_reg.data_oe <= 1'b0;
    end else begin
      pin_reg.data_oe <= !sync2_reg.cs_n;
    end
  end

  // data pin level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_reg.data_o <= 1'b0;
    end else begin
      case (state_reg)
        st_convert: begin
          pin_reg.data_o <= 1'b1;
        end
        st_sleep: begin
          pin_reg.data_o <= 1'b0;
        end
        st_output: begin
          pin_reg.data_o <= shift_reg[`RESULT_BITS-1];
        end
        default: begin
          pin_reg.data_o <= 1'b0;
        end
      endcase
    end
  end

  assign data_o = pin_reg.data_o;
  assign data_oe = pin_reg.data_oe;
  assign converting = (state_reg == st_convert);
endmodule
`default_nettype wire

/* adc_serial_result_port_tb.sv */
// self-checking bench for the serial result port
`timescale 1ns/1ps
`default_nettype none
module adc_serial_result_port_tb;
  import adc_port_pkg::*;
  logic clk, resetn, sample_valid, sample_ready;
  logic data_o, data_oe, converting, cs_n, sck, s;
  logic [15:0] sample_data, w;
  wire sdo;
  int n_errors = 0, checked = 0, cyc = 0;
  logic [15:0] rows [4] = '{16'h7fff, 16'hffff, 16'h0000, 16'ha5c3};
  assign sdo = data_oe ? data_o : 1'bz;
  spi_host_model host (.cs_n(cs_n), .sck(sck), .sdo(sdo));
  adc_serial_result_port #(.CONV_CYCLES(200)) DUT (.clk(clk),
    .resetn(resetn), .cs_n(cs_n), .sck(sck), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .data_o(data_o), .data_oe(data_oe), .converting(converting));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ready;
    for (int k = 0; k < 400 && converting !== 1'b0; k++) @(posedge clk);
    cmp(converting, 1'b0);
  endtask
  task automatic complete_run;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    resetn = 1'b0;
    sample_valid = 1'b0;
    sample_data = 16'h0000;
    repeat (8) @(posedge clk);
    #1 cmp({data_oe, converting}, 2'b01);
    resetn <= 1'b1;
    sample_valid <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      sample_data <= i < 4 ? rows[i] : 16'h1234;
      @(posedge clk);
    end
    #1 cmp(sample_ready, 1'b0);
    sample_valid <= 1'b0;
    host.poll(s);
    cmp(s, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wait_ready();
      host.poll(s);
      cmp(s, 1'b0);
      host.read(16, w);
      cmp(w, rows[i]);
      cmp(converting, 1'b1);
      $display("row %0d done", i);
    end
    @(posedge clk);
    sample_data <= 16'hf0f0;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    wait_ready();
    host.read(4, w);
    cmp(w, 16'hf000);
    cmp(converting, 1'b1);
    wait_ready();
    host.read(16, w);
    cmp(w, 16'h8000);
    $display("abort and empty done");
    complete_run();
  end
endmodule
`default_nettype wire

/* result_fifo.sv */
// small valid/ready fifo for conversion results
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* spi_host_model.sv */
// behavioural spi host: select, clock, capture
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output var logic cs_n,
  output var logic sck,
  input wire logic sdo
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
  end
  task automatic poll(output logic s);
    cs_n = 1'b0;
    #100 s = sdo;
    cs_n = 1'b1;
    #100;
  endtask
  task automatic read(input int n, output logic [15:0] w);
    w = 16'h0000;
    cs_n = 1'b0;
    #100 sck = 1'b0;
    for (int i = 0; i < n; i++) begin
      #62.5 sck = 1'b1;
      w[15-i] = sdo;
      #62.5 sck = 1'b0;
    end
    #62.5 sck = 1'b1;
    cs_n = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire
